/* rtl/lil_pkg.sv */
package lil_pkg;

	// ----------------------------------------------------------------
	// Widths and instruction fields
	// ----------------------------------------------------------------
	localparam int XLEN = 64;
	localparam int IW = 32;
	localparam int RIDX_W = 5;
	localparam int PFX_W = 24;
	localparam int IMM_W = 16;
	localparam int OPC_LO = 26;
	localparam int OPC_W = 6;
	localparam int RD_LO = 21;
	localparam int RA_LO = 16;
	localparam int RB_LO = 11;
	localparam int FUNC_W = 11;
	localparam int PFX_SEL_LO = 24;
	localparam int PFX_SEL_W = 2;
	localparam int SWAP_BIT = 9;
	localparam int ALIGN_W = 3;
	localparam int BYTE_W = 8;
	localparam int NBYTES = 8;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_PREFIX = 6'h2c;
	localparam logic [5:0] OPC_LDX = 6'h32;
	localparam logic [5:0] OPC_LDI = 6'h3b;
	localparam logic [5:0] OPC_ORL = 6'h20;
	localparam logic [5:0] OPC_ORLI = 6'h28;
	localparam logic [5:0] OPC_ORLI2 = 6'h1a;
	localparam logic [1:0] PFX_SEL = 2'h2;
	localparam logic [10:0] FUNC_ORL = 11'h100;
	localparam logic [10:0] FUNC_LDX = 11'h100;
	localparam logic [10:0] FUNC_LDX_MASK = 11'h5ff;
	localparam logic [4:0] ORLI2_SEL = 5'h10;
	localparam logic [4:0] CAUSE_TLB = 5'h12;
	localparam logic [4:0] CAUSE_ZONE = 5'h10;
	localparam logic [4:0] CAUSE_ALIGN = 5'h01;

	// ----------------------------------------------------------------
	// Counts
	// ----------------------------------------------------------------
	localparam int LAT_FAST = 2;
	localparam int LAT_SLOW = 3;
	localparam int AREA_SLOW = 1;
	localparam logic [1:0] PCNT_NONE = 2'h0;
	localparam logic [1:0] PCNT_ONE = 2'h1;
	localparam logic [1:0] PCNT_TWO = 2'h2;
	localparam logic [1:0] LDCNT_IDLE = 2'h0;
	localparam logic [1:0] LDCNT_RETIRE = 2'h1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {FK_NONE, FK_TLB, FK_ZONE, FK_ALIGN} lil_fault_kind_t;

	typedef struct packed {
		logic saved_user;
		logic saved_virt;
		logic user;
		logic virt;
	} lil_mode_t;

	typedef struct packed {
		logic [4:0] cause;
		logic store_flag;
		logic size_flag;
		logic zone_flag;
		logic [RIDX_W-1:0] reg_idx;
	} lil_fault_t;

	typedef struct packed {
		logic valid;
		logic [RIDX_W-1:0] idx;
		logic [XLEN-1:0] data;
	} lil_wb_t;

	typedef struct packed {
		logic [XLEN-1:0] data;
		logic tlb_miss;
		logic zone_deny;
	} lil_mem_ans_t;

	localparam lil_mode_t MODE_RESET = '0;
	localparam lil_fault_t FAULT_RESET = '0;
	localparam lil_wb_t WB_RESET = '0;

endpackage : lil_pkg

/* rtl/lil_load_chk.sv */
`timescale 1ns/1ps
module lil_load_chk (
	// Access under test
	input wire logic [lil_pkg::XLEN-1:0] addr,
	input lil_pkg::lil_mem_ans_t ans,
	input lil_pkg::lil_mode_t mode,
	input wire logic swap,
	// Verdict and data
	output lil_pkg::lil_fault_kind_t kind,
	output logic [lil_pkg::XLEN-1:0] data
);
	import lil_pkg::*;

	logic [XLEN-1:0] data_rev;

	// ----------------------------------------------------------------
	// Byte reversal
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NBYTES; g++) begin : g_rev
		assign data_rev[g*BYTE_W +: BYTE_W] = ans.data[(NBYTES-1-g)*BYTE_W +: BYTE_W];
	end

	assign data = swap ? data_rev : ans.data;

	// ----------------------------------------------------------------
	// Fault priority
	// ----------------------------------------------------------------
	always_comb begin
		if (mode.virt && ans.tlb_miss) begin
			kind = FK_TLB;
		end else if (mode.user && mode.virt && ans.zone_deny) begin
			kind = FK_ZONE;
		end else if (addr[ALIGN_W-1:0] != '0) begin
			kind = FK_ALIGN;
		end else begin
			kind = FK_NONE;
		end
	end

endmodule : lil_load_chk

/* rtl/lil_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - Prefix field held and locked for next
// - One prefix gives 40-bit immediate
// - Two prefixes give full 64-bit immediate
// - Non-immediate follower drops held prefix silently
// - No interrupt between prefix and follower
// - Indexed load address is sum of sources
// - Swap bit reverses loaded byte order
// - Swapped load legal only with reorder enabled
// - Translation miss: cause 10010, modes saved
// - Zone block: cause 10000, zone flag set
// - Misaligned: cause 00001, size flag, index
// - Miss, zone, align priority; destination kept
// - Loads take two or three cycles
// - Offset load uses source plus immediate
// - Unprefixed immediate is sign-extended sixteen bits
// - Offset load has same fault checks
// - Register OR of two sources
// - Immediate OR, one cycle, two forms
module lil_core #(
	parameter int area_opt_level = 0,
	parameter int reorder_ops_enable = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Instruction stream
	input wire logic instr_valid,
	input wire logic [lil_pkg::IW-1:0] instr,
	output logic instr_ready,
	// Operands read for the offered instruction
	input wire logic [lil_pkg::XLEN-1:0] first_long_src,
	input wire logic [lil_pkg::XLEN-1:0] second_long_src,
	input wire logic [lil_pkg::XLEN-1:0] dest_long_src,
	// Write-back
	output lil_pkg::lil_wb_t wb,
	// Data memory and translation
	output logic mem_rd,
	output logic [lil_pkg::XLEN-1:0] mem_addr,
	input lil_pkg::lil_mem_ans_t mem_ans,
	// Machine state
	input wire logic mode_wr_en,
	input lil_pkg::lil_mode_t mode_wr_data,
	output lil_pkg::lil_mode_t machine_state_word,
	output lil_pkg::lil_fault_t fault_status_word,
	output logic fault_pulse,
	output logic illegal_pulse,
	// Interrupt gate
	input wire logic irq_req,
	output logic irq_grant
);
	import lil_pkg::*;

	localparam int LD_LAT = (area_opt_level == AREA_SLOW) ? LAT_SLOW : LAT_FAST;
	localparam logic [1:0] LD_CNT_INIT = 2'(LD_LAT - 1);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic [OPC_W-1:0] opc_of(input logic [IW-1:0] i);
		return i[OPC_LO +: OPC_W];
	endfunction : opc_of

	function automatic logic is_typeb(input logic [IW-1:0] i);
		return (opc_of(i) == OPC_LDI) || (opc_of(i) == OPC_ORLI)
			|| ((opc_of(i) == OPC_ORLI2) && (i[RA_LO +: RIDX_W] == ORLI2_SEL));
	endfunction : is_typeb

	logic ready_q;
	logic [1:0] pcnt_q;
	logic [PFX_W-1:0] first_q;
	logic [PFX_W-1:0] second_q;
	logic [1:0] ld_cnt_q;
	logic mem_rd_q;
	logic [XLEN-1:0] mem_addr_q;
	logic [RIDX_W-1:0] ld_dst_q;
	logic ld_swap_q;
	lil_mem_ans_t ans_q;
	lil_wb_t wb_q;
	lil_mode_t mode_q;
	lil_fault_t fault_q;
	logic fault_pulse_q;
	logic illegal_q;
	logic irq_grant_q;

	logic fire;
	logic [OPC_W-1:0] opc;
	logic [RIDX_W-1:0] rd;
	logic [IMM_W-1:0] imm16;
	logic [FUNC_W-1:0] func;
	logic is_prefix;
	logic is_ldx;
	logic ldx_bad;
	logic is_ldi;
	logic is_orl;
	logic is_orli3;
	logic is_orli2;
	logic ld_start;
	logic ld_retire;
	logic [XLEN-1:0] imm_ext;
	lil_mem_ans_t ans_sel;
	lil_fault_kind_t chk_kind;
	logic [XLEN-1:0] chk_data;

	assign fire = instr_valid && ready_q;
	assign opc = opc_of(instr);
	assign rd = instr[RD_LO +: RIDX_W];
	assign imm16 = instr[IMM_W-1:0];
	assign func = instr[FUNC_W-1:0];
	assign is_prefix = (opc == OPC_PREFIX) && (instr[PFX_SEL_LO +: PFX_SEL_W] == PFX_SEL);
	assign is_ldx = (opc == OPC_LDX) && ((func & FUNC_LDX_MASK) == FUNC_LDX);
	assign ldx_bad = is_ldx && func[SWAP_BIT] && (reorder_ops_enable != 1);
	assign is_ldi = opc == OPC_LDI;
	assign is_orl = (opc == OPC_ORL) && (func == FUNC_ORL);
	assign is_orli3 = opc == OPC_ORLI;
	assign is_orli2 = (opc == OPC_ORLI2) && (instr[RA_LO +: RIDX_W] == ORLI2_SEL);
	assign ld_start = fire && ((is_ldx && !ldx_bad) || is_ldi);
	assign ld_retire = ld_cnt_q == LDCNT_RETIRE;

	// ----------------------------------------------------------------
	// Immediate assembly
	// ----------------------------------------------------------------
	always_comb begin
		unique case (pcnt_q)
			PCNT_ONE: imm_ext = {{(XLEN-PFX_W-IMM_W){first_q[PFX_W-1]}}, first_q, imm16};
			PCNT_TWO: imm_ext = {first_q, second_q, imm16};
			default: imm_ext = {{(XLEN-IMM_W){imm16[IMM_W-1]}}, imm16};
		endcase
	end

	// ----------------------------------------------------------------
	// Prefix holding
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcnt_q <= PCNT_NONE;
			first_q <= '0;
			second_q <= '0;
		end else if (fire) begin
			if (is_prefix) begin
				unique case (pcnt_q)
					PCNT_NONE: begin
						first_q <= instr[PFX_W-1:0];
						pcnt_q <= PCNT_ONE;
					end
					PCNT_ONE: begin
						second_q <= instr[PFX_W-1:0];
						pcnt_q <= PCNT_TWO;
					end
					default: begin
						first_q <= second_q;
						second_q <= instr[PFX_W-1:0];
						pcnt_q <= PCNT_TWO;
					end
				endcase
			end else begin
				pcnt_q <= PCNT_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Issue and load sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_q <= 1'b1;
			ld_cnt_q <= LDCNT_IDLE;
			mem_rd_q <= 1'b0;
			mem_addr_q <= '0;
			ld_dst_q <= '0;
			ld_swap_q <= 1'b0;
		end else begin
			mem_rd_q <= ld_start;
			if (ld_start) begin
				ready_q <= 1'b0;
				ld_cnt_q <= LD_CNT_INIT;
				ld_dst_q <= rd;
				ld_swap_q <= is_ldx && func[SWAP_BIT];
				if (is_ldx) begin
					mem_addr_q <= first_long_src + second_long_src;
				end else begin
					mem_addr_q <= first_long_src + imm_ext;
				end
			end else if (ld_cnt_q != LDCNT_IDLE) begin
				ld_cnt_q <= ld_cnt_q - LDCNT_RETIRE;
				if (ld_retire) begin
					ready_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ans_q <= '0;
		end else if (mem_rd_q) begin
			ans_q <= mem_ans;
		end
	end

	// Slow build answers from the extra stage
	assign ans_sel = (LD_LAT > LAT_FAST) ? ans_q : mem_ans;

	lil_load_chk u_chk (
		.addr(mem_addr_q),
		.ans(ans_sel),
		.mode(mode_q),
		.swap(ld_swap_q),
		.kind(chk_kind),
		.data(chk_data)
	);

	// ----------------------------------------------------------------
	// Result write-back
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_q <= WB_RESET;
		end else begin
			wb_q.valid <= 1'b0;
			if (fire && is_orl) begin
				wb_q <= '{valid: 1'b1, idx: rd,
					data: first_long_src | second_long_src};
			end else if (fire && is_orli3) begin
				wb_q <= '{valid: 1'b1, idx: rd, data: first_long_src | imm_ext};
			end else if (fire && is_orli2) begin
				wb_q <= '{valid: 1'b1, idx: rd, data: dest_long_src | imm_ext};
			end else if (ld_retire && (chk_kind == FK_NONE)) begin
				wb_q <= '{valid: 1'b1, idx: ld_dst_q, data: chk_data};
			end
		end
	end

	// ----------------------------------------------------------------
	// Machine state and fault status
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= MODE_RESET;
			fault_q <= FAULT_RESET;
			fault_pulse_q <= 1'b0;
		end else begin
			fault_pulse_q <= ld_retire && (chk_kind != FK_NONE);
			if (mode_wr_en) begin
				mode_q <= mode_wr_data;
			end
			if (ld_retire) begin
				unique case (chk_kind)
					FK_TLB: begin
						fault_q.cause <= CAUSE_TLB;
						fault_q.store_flag <= 1'b0;
						mode_q <= '{saved_user: mode_q.user, saved_virt: mode_q.virt,
							user: 1'b0, virt: 1'b0};
					end
					FK_ZONE: begin
						fault_q.cause <= CAUSE_ZONE;
						fault_q.store_flag <= 1'b0;
						fault_q.zone_flag <= 1'b1;
						mode_q <= '{saved_user: mode_q.user, saved_virt: mode_q.virt,
							user: 1'b0, virt: 1'b0};
					end
					FK_ALIGN: begin
						fault_q.cause <= CAUSE_ALIGN;
						fault_q.size_flag <= 1'b1;
						fault_q.store_flag <= 1'b0;
						fault_q.reg_idx <= ld_dst_q;
					end
					FK_NONE: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Illegal report and interrupt gate
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			illegal_q <= 1'b0;
			irq_grant_q <= 1'b0;
		end else begin
			illegal_q <= fire && ldx_bad;
			irq_grant_q <= irq_req && ready_q && !fire && (pcnt_q == PCNT_NONE);
		end
	end

	assign instr_ready = ready_q;
	assign wb = wb_q;
	assign mem_rd = mem_rd_q;
	assign mem_addr = mem_addr_q;
	assign machine_state_word = mode_q;
	assign fault_status_word = fault_q;
	assign fault_pulse = fault_pulse_q;
	assign illegal_pulse = illegal_q;
	assign irq_grant = irq_grant_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_prefix_lock;
		@(posedge core_clk) disable iff (sys_rst)
		fire && is_prefix && (pcnt_q == PCNT_NONE)
			|=> (pcnt_q == PCNT_ONE) && (first_q == $past(instr[PFX_W-1:0]));
	endproperty
	a_prefix_lock: assert property (p_prefix_lock) else $error("prefix not held");

	property p_imm40;
		@(posedge core_clk) disable iff (sys_rst)
		fire && is_orli3 && (pcnt_q == PCNT_ONE)
			|=> wb_q.valid && (wb_q.data == ($past(first_long_src)
			| {{(XLEN-PFX_W-IMM_W){$past(first_q[PFX_W-1])}}, $past(first_q),
			$past(instr[IMM_W-1:0])}));
	endproperty
	a_imm40: assert property (p_imm40) else $error("40-bit immediate wrong");

	property p_imm64;
		@(posedge core_clk) disable iff (sys_rst)
		fire && is_orli2 && (pcnt_q == PCNT_TWO)
			|=> wb_q.data == ($past(dest_long_src)
			| {$past(first_q), $past(second_q), $past(instr[IMM_W-1:0])});
	endproperty
	a_imm64: assert property (p_imm64) else $error("64-bit immediate wrong");

	property p_release;
		@(posedge core_clk) disable iff (sys_rst)
		fire && !is_prefix |=> pcnt_q == PCNT_NONE;
	endproperty
	a_release: assert property (p_release) else $error("prefix not released");

	property p_irq_block;
		@(posedge core_clk) disable iff (sys_rst)
		(pcnt_q != PCNT_NONE) || fire |=> !irq_grant_q;
	endproperty
	a_irq_block: assert property (p_irq_block) else $error("interrupt inside prefix pair");

	property p_ld_latency;
		@(posedge core_clk) disable iff (sys_rst)
		ld_start |=> !ready_q [*1] ##(LD_LAT-1) (ready_q && (wb_q.valid || fault_pulse_q));
	endproperty
	a_ld_latency: assert property (p_ld_latency) else $error("load latency wrong");

	property p_ld_keep;
		@(posedge core_clk) disable iff (sys_rst)
		fault_pulse_q |-> !wb_q.valid && $stable(ready_q) == 1'b0;
	endproperty
	a_ld_keep: assert property (p_ld_keep) else $error("faulted load wrote back");

	property p_tlb;
		@(posedge core_clk) disable iff (sys_rst)
		ld_retire && (chk_kind == FK_TLB) |=> (fault_q.cause == CAUSE_TLB)
			&& !mode_q.user && !mode_q.virt && mode_q.saved_virt && fault_pulse_q;
	endproperty
	a_tlb: assert property (p_tlb) else $error("translation miss state wrong");

	property p_align;
		@(posedge core_clk) disable iff (sys_rst)
		ld_retire && (chk_kind == FK_ALIGN) |=> (fault_q.cause == CAUSE_ALIGN)
			&& fault_q.size_flag && (fault_q.reg_idx == $past(ld_dst_q));
	endproperty
	a_align: assert property (p_align) else $error("misalign state wrong");

	property p_orl;
		@(posedge core_clk) disable iff (sys_rst)
		fire && is_orl |=> wb_q.valid && (wb_q.idx == $past(rd))
			&& (wb_q.data == ($past(first_long_src) | $past(second_long_src)));
	endproperty
	a_orl: assert property (p_orl) else $error("register OR wrong");

	property p_reorder;
		@(posedge core_clk) disable iff (sys_rst)
		fire && ldx_bad |=> illegal_q && ready_q && !mem_rd_q;
	endproperty
	a_reorder: assert property (p_reorder) else $error("swapped load accepted");

endmodule : lil_core

/* verif/lil_mem_model.sv */
`timescale 1ns/1ps
module lil_mem_model (
	// Clock and request
	input wire logic core_clk,
	input wire logic mem_rd,
	input wire logic [lil_pkg::XLEN-1:0] mem_addr,
	// Fault steering from the bench
	input wire logic miss_en,
	input wire logic deny_en,
	// Answer
	output lil_pkg::lil_mem_ans_t mem_ans
);
	import lil_pkg::*;
	logic [7:0] junk_q = 8'h00;
	always_ff @(posedge core_clk) begin
		junk_q <= junk_q + 8'h01;
	end
	// Answer only in the request cycle, garbage otherwise
	always_comb begin
		if (mem_rd) begin
			mem_ans.data = {~mem_addr[31:0], mem_addr[31:0]};
			mem_ans.tlb_miss = miss_en;
			mem_ans.zone_deny = deny_en;
		end else begin
			mem_ans.data = {8{junk_q}};
			mem_ans.tlb_miss = junk_q[0];
			mem_ans.zone_deny = junk_q[1];
		end
	end
endmodule : lil_mem_model

/* verif/lil_core_tb.sv */
`timescale 1ns/1ps
module lil_core_tb;
	import lil_pkg::*;
	localparam int AREA = 0;
	localparam int LD_LAT = (AREA == 1) ? 3 : 2;
	typedef struct {
		logic [31:0] w;
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] d;
		logic [63:0] e;
		int lat;
	} lil_row_t;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic iv = 1'b0;
	logic [31:0] iw = '0;
	logic [63:0] s1 = '0;
	logic [63:0] s2 = '0;
	logic [63:0] s3 = '0;
	logic mwe = 1'b0;
	lil_mode_t mwd = '0;
	logic irq = 1'b0;
	logic miss = 1'b0;
	logic deny = 1'b0;
	logic ird, mrd, fp, ip, gnt;
	logic [63:0] madr;
	lil_mem_ans_t ans;
	lil_mode_t msw;
	lil_fault_t fsw;
	lil_wb_t wb;
	lil_wb_t got_wb;
	logic got_f;
	int got_lat;
	logic mrd2, fp2, ip2;
	logic [63:0] madr2;
	lil_mem_ans_t ans2;
	lil_mode_t msw2;
	lil_fault_t fsw2;
	lil_wb_t wb2;
	lil_wb_t alt_wb;
	logic alt_f;
	logic alt_ip;
	int alt_lat;
	int miscompares = 0;
	int check_count = 0;
	lil_row_t rows [5];

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	lil_core #(.area_opt_level(AREA), .reorder_ops_enable(1)) lil_core_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(iv), .instr(iw),
		.instr_ready(ird), .first_long_src(s1), .second_long_src(s2),
		.dest_long_src(s3), .wb(wb), .mem_rd(mrd), .mem_addr(madr), .mem_ans(ans),
		.mode_wr_en(mwe), .mode_wr_data(mwd), .machine_state_word(msw),
		.fault_status_word(fsw), .fault_pulse(fp), .illegal_pulse(ip),
		.irq_req(irq), .irq_grant(gnt)
	);
	lil_mem_model lil_mem_model_inst (
		.core_clk(core_clk), .mem_rd(mrd), .mem_addr(madr),
		.miss_en(miss), .deny_en(deny), .mem_ans(ans)
	);
	// Slow build without reorder support, run in lockstep
	if (1) begin : g_alt
		lil_core #(.area_opt_level(AREA_SLOW), .reorder_ops_enable(0)) lil_core_inst (
			.core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(iv), .instr(iw),
			.instr_ready(), .first_long_src(s1), .second_long_src(s2),
			.dest_long_src(s3), .wb(wb2), .mem_rd(mrd2), .mem_addr(madr2), .mem_ans(ans2),
			.mode_wr_en(mwe), .mode_wr_data(mwd), .machine_state_word(msw2),
			.fault_status_word(fsw2), .fault_pulse(fp2), .illegal_pulse(ip2),
			.irq_req(irq), .irq_grant()
		);
		lil_mem_model lil_mem_model_inst (
			.core_clk(core_clk), .mem_rd(mrd2), .mem_addr(madr2),
			.miss_en(miss), .deny_en(deny), .mem_ans(ans2)
		);
	end

	// ----------------------------------------------------------------
	// Encoding and expectation helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rw(logic [5:0] op, logic [4:0] d, logic [4:0] a,
		logic [15:0] lo);
		return {op, d, a, lo};
	endfunction : rw
	function automatic logic [31:0] pfx(logic [23:0] p);
		return {OPC_PREFIX, PFX_SEL, p};
	endfunction : pfx
	function automatic logic [63:0] memw(logic [63:0] a);
		return {~a[31:0], a[31:0]};
	endfunction : memw
	function automatic logic [63:0] bswap(logic [63:0] v);
		logic [63:0] r;
		for (int i = 0; i < 8; i++) begin
			r[8*i +: 8] = v[8*(7-i) +: 8];
		end
		return r;
	endfunction : bswap

	// ----------------------------------------------------------------
	// Compare tasks and bus drivers
	// ----------------------------------------------------------------
	task automatic note(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : note
	task automatic chk_wb(input lil_wb_t g, input lil_wb_t e);
		note(g === e, "write-back");
	endtask : chk_wb
	task automatic chk_flt(input lil_fault_t g, input lil_fault_t e);
		note(g === e, "fault status");
	endtask : chk_flt
	task automatic chk_mode(input lil_mode_t g, input lil_mode_t e);
		note(g === e, "machine state");
	endtask : chk_mode
	task automatic chk_bit(input logic g, input logic e, input string what);
		note(g === e, what);
	endtask : chk_bit
	task automatic chk_lat(input int g, input int e);
		note(g == e, "latency");
	endtask : chk_lat
	task automatic send(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
		input logic [63:0] d);
		int n;
		iv <= 1'b1;
		iw <= w;
		s1 <= a;
		s2 <= b;
		s3 <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ird !== 1'b1 && n < 20);
		if (n >= 20) note(1'b0, "instruction never taken");
	endtask : send
	task automatic res();
		iv <= 1'b0;
		got_lat = 0;
		got_f = 1'b0;
		got_wb = '0;
		alt_lat = 0;
		alt_f = 1'b0;
		alt_ip = 1'b0;
		alt_wb = '0;
		for (int k = 1; k <= 8; k++) begin
			@(negedge core_clk);
			if (got_lat == 0 && (wb.valid === 1'b1 || fp === 1'b1 || ip === 1'b1)) begin
				got_lat = k;
				got_wb = wb;
				got_f = fp;
			end
			if (alt_lat == 0 && (wb2.valid === 1'b1 || fp2 === 1'b1 || ip2 === 1'b1)) begin
				alt_lat = k;
				alt_wb = wb2;
				alt_f = fp2;
				alt_ip = ip2;
			end
		end
		@(posedge core_clk);
	endtask : res
	task automatic wmode(input lil_mode_t m);
		mwd <= m;
		mwe <= 1'b1;
		@(posedge core_clk);
		mwe <= 1'b0;
	endtask : wmode
	task automatic results();
		$display("checks %0d, miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	initial begin
		#20000;
		note(1'b0, "watchdog expired");
		results();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rows[0] = '{rw(OPC_ORL, 5'd3, 5'd1, {5'd2, FUNC_ORL}), 64'hf0f0_0000_1234_0000,
			64'h0f00_00ff_0000_5678, '0, 64'hfff0_00ff_1234_5678, 1};
		rows[1] = '{rw(OPC_ORLI2, 5'd4, ORLI2_SEL, 16'h8001), '0, '0, 64'h0f00,
			64'hffff_ffff_ffff_8f01, 1};
		rows[2] = '{rw(OPC_LDX, 5'd5, 5'd1, {5'd2, FUNC_LDX}), 64'h1000, 64'h238, '0,
			memw(64'h1238), LD_LAT};
		rows[3] = '{rw(OPC_LDX, 5'd5, 5'd1, {5'd2, 11'h300}), 64'h1000, 64'h238, '0,
			bswap(memw(64'h1238)), LD_LAT};
		rows[4] = '{rw(OPC_LDI, 5'd6, 5'd1, 16'hfff8), 64'h2000, '0, '0,
			memw(64'h1ff8), LD_LAT};
		repeat (2) @(posedge core_clk);
		chk_bit(ird, 1'b1, "ready in reset");
		chk_mode(msw, '0);
		chk_flt(fsw, '0);
		repeat (1) @(posedge core_clk);
		sys_rst <= 1'b0;
		$display("test reset done");
		foreach (rows[i]) begin
			send(rows[i].w, rows[i].a, rows[i].b, rows[i].d);
			res();
			chk_lat(got_lat, rows[i].lat);
			chk_wb(got_wb, '{1'b1, rows[i].w[25:21], rows[i].e});
			if (i == 3) begin
				chk_bit(alt_ip & ~alt_wb.valid, 1'b1, "swapped load not refused");
			end else begin
				chk_lat(alt_lat, (rows[i].lat == 1) ? 1 : LAT_SLOW);
				chk_wb(alt_wb, '{1'b1, rows[i].w[25:21], rows[i].e});
			end
			$display("test row %0d done", i);
		end
		chk_bit(madr === 64'h1ff8, 1'b1, "load address");
		// One prefix ahead of ORLI, two prefixes ahead of both immediate OR forms
		send(pfx(24'h80_0001), '0, '0, '0);
		send(rw(OPC_ORLI, 5'd7, 5'd1, 16'h0002), 64'h10, '0, '0);
		res();
		chk_wb(got_wb, '{1'b1, 5'd7, 64'hffff_ff80_0001_0012});
		chk_lat(got_lat, 1);
		send(pfx(24'h12_3456), '0, '0, '0);
		send(pfx(24'hab_cdef), '0, '0, '0);
		send(rw(OPC_ORLI, 5'd7, 5'd1, 16'h0f00), 64'h1, '0, '0);
		res();
		chk_wb(got_wb, '{1'b1, 5'd7, 64'h1234_56ab_cdef_0f01});
		send(pfx(24'hfe_dcba), '0, '0, '0);
		send(pfx(24'h98_7654), '0, '0, '0);
		send(rw(OPC_ORLI2, 5'd9, ORLI2_SEL, 16'h3210), '0, '0, 64'h8);
		res();
		chk_wb(got_wb, '{1'b1, 5'd9, 64'hfedc_ba98_7654_3218});
		$display("test prefixes done");
		// Prefix dropped by a register-form follower, then a zero prefix used by an offset load
		send(pfx(24'hff_ffff), '0, '0, '0);
		send(rw(OPC_ORL, 5'd8, 5'd1, {5'd2, FUNC_ORL}), 64'h1, 64'h2, '0);
		res();
		chk_wb(got_wb, '{1'b1, 5'd8, 64'h3});
		send(rw(OPC_ORLI2, 5'd9, ORLI2_SEL, 16'h0001), '0, '0, '0);
		res();
		chk_wb(got_wb, '{1'b1, 5'd9, 64'h1});
		send(pfx(24'h00_0000), '0, '0, '0);
		send(rw(OPC_LDI, 5'd6, 5'd1, 16'h8000), 64'h1000, '0, '0);
		res();
		chk_wb(got_wb, '{1'b1, 5'd6, memw(64'h9000)});
		$display("test prefix drop done");
		// Interrupt gate around a held prefix
		irq <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk_bit(gnt, 1'b1, "grant while idle");
		send(pfx(24'h00_0001), '0, '0, '0);
		iv <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk_bit(gnt, 1'b0, "grant with prefix held");
		send(rw(OPC_ORLI, 5'd7, 5'd1, 16'h0000), '0, '0, '0);
		res();
		chk_wb(got_wb, '{1'b1, 5'd7, 64'h1_0000});
		irq <= 1'b0;
		$display("test interrupt gate done");
		// Faults, highest priority first
		wmode('{1'b0, 1'b0, 1'b1, 1'b1});
		miss <= 1'b1;
		deny <= 1'b1;
		send(rw(OPC_LDX, 5'd10, 5'd1, {5'd2, FUNC_LDX}), 64'h1001, '0, '0);
		res();
		chk_bit(got_f & ~got_wb.valid, 1'b1, "miss fault");
		chk_lat(got_lat, LD_LAT);
		chk_flt(fsw, '{CAUSE_TLB, 1'b0, 1'b0, 1'b0, 5'd0});
		chk_mode(msw, '{1'b1, 1'b1, 1'b0, 1'b0});
		chk_bit(alt_f & ~alt_wb.valid, 1'b1, "slow miss fault");
		chk_lat(alt_lat, LAT_SLOW);
		chk_flt(fsw2, '{CAUSE_TLB, 1'b0, 1'b0, 1'b0, 5'd0});
		wmode('{1'b0, 1'b0, 1'b1, 1'b1});
		miss <= 1'b0;
		send(rw(OPC_LDI, 5'd11, 5'd1, 16'h0000), 64'h3003, '0, '0);
		res();
		chk_bit(got_f & ~got_wb.valid, 1'b1, "zone fault");
		chk_flt(fsw, '{CAUSE_ZONE, 1'b0, 1'b0, 1'b1, 5'd0});
		chk_mode(msw, '{1'b1, 1'b1, 1'b0, 1'b0});
		miss <= 1'b1;
		send(rw(OPC_LDI, 5'd12, 5'd1, 16'h0000), 64'h4004, '0, '0);
		res();
		chk_bit(got_f & ~got_wb.valid, 1'b1, "align fault");
		chk_flt(fsw, '{CAUSE_ALIGN, 1'b0, 1'b1, 1'b1, 5'd12});
		chk_mode(msw, '{1'b1, 1'b1, 1'b0, 1'b0});
		chk_flt(fsw2, '{CAUSE_ALIGN, 1'b0, 1'b1, 1'b1, 5'd12});
		chk_mode(msw2, '{1'b1, 1'b1, 1'b0, 1'b0});
		$display("test faults done");
		results();
	end
endmodule : lil_core_tb
